/* hdl/ced_bus_if.sv */
`timescale 1ns/1ps
interface ced_bus_if;
	logic dev_drv;   // device node drive, 0 is dominant
	logic peer_drv;  // far node drive, 0 is dominant
	logic bit_tick;  // one pulse per bit time
	logic bus;       // resolved bus level

	// wired-and: any dominant driver wins
	assign bus = dev_drv & peer_drv;

	modport dev (output dev_drv, output bit_tick, input bus);
	modport peer (output peer_drv, input bit_tick, input bus);
endinterface // ced_bus_if

/* hdl/ced_defines.svh */
`ifndef CED_DEFINES_SVH
`define CED_DEFINES_SVH
// bit time in clock cycles
`define CED_BIT_CYC     10
// frame layout, destuffed bit positions
`define CED_ARB_END     8'h0c
`define CED_P_DLC       8'h0f
`define CED_P_DAT       8'h13
`define CED_CRC_LEN     8'h0f
`define CED_EOF_LEN     8'h07
`define CED_CRC_POLY    15'h4599
`define CED_STUFF_MAX   3'h5
// error signalling
`define CED_FLAG_LEN    8'h06
`define CED_DELIM_LEN   8'h08
// error kinds, bit positions in err_kind
`define CED_E_BIT       0
`define CED_E_STUFF     1
`define CED_E_FORM      2
`define CED_E_ACK       3
`define CED_E_CRC       4
// counters
`define CED_TEC_INC     9'h008
`define CED_REC_INC     9'h001
`define CED_PASSIVE_LIM 9'h07f
`define CED_BUSOFF_LIM  9'h0ff
`define CED_CNT_MAX     9'h1ff
`endif

/* hdl/ced_node_dev.sv */
// Overview of operation
// - transmitter flags bit error on monitored mismatch
// - stuff opposite bit after five equal bits
// - receiver drops stuff bits before processing
// - six equal bits in stuffed region: stuff error
// - fixed-format fields checked, bad value: form error
// - receivers drive dominant in acknowledge slot
// - recessive acknowledge seen by transmitter: ack error
// - transmit 15-bit crc, receivers check it
// - detector sends error flag, frame discarded
// - receive error adds one to receive counter
// - transmit error adds eight to transmit counter
// - good frame decrements the matching counter
// - error active node sends active (dominant) flags
// - counter above 127: passive, passive flags only
// - passive node still transmits and receives
// - passive returns active as counters fall
// - transmit counter above 255 enters bus-off
// - bus-off node silent until user recovery
`timescale 1ns/1ps
module ced_node_dev
	import ced_pkg::*;
#(
	parameter int BIT_CYC = `CED_BIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	ced_bus_if.dev           link,
	input  wire logic        tx_req,
	input  wire logic [10:0] tx_id,
	input  wire logic [3:0]  tx_dlc,
	input  wire logic [63:0] tx_data,
	input  wire logic        recover,
	output logic             tx_busy,
	output logic             tx_done,
	output logic             rx_valid,
	output logic [10:0]      rx_id,
	output logic [3:0]       rx_dlc,
	output logic [63:0]      rx_data,
	output logic             err_pulse,
	output logic [4:0]       err_kind,
	output logic [8:0]       tec,
	output logic [8:0]       rec,
	output ced_conf_t        conf
);
	if (BIT_CYC < 2 || BIT_CYC > 256) begin : g_chk
		$error("BIT_CYC must lie in 2..256");
	end

	logic [7:0]  div_reg, div_next;
	logic        tick_reg, tick_next;
	ced_st_t     st_reg, st_next;
	ced_conf_t   conf_reg, conf_next;
	logic [7:0]  pos_reg, pos_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        last_reg, last_next;
	logic [14:0] crc_reg, crc_next;
	logic        cbad_reg, cbad_next;
	logic        txr_reg, txr_next;
	logic        drv_reg, drv_next;
	logic        pend_reg, pend_next;
	logic [82:0] fr_reg, fr_next;
	logic [82:0] tsh_reg, tsh_next;
	logic [10:0] id_reg, id_next;
	logic [3:0]  dlc_reg, dlc_next;
	logic [63:0] dat_reg, dat_next;
	logic [8:0]  tec_reg, tec_next;
	logic [8:0]  rec_reg, rec_next;
	logic        done_reg, done_next;
	logic        rxv_reg, rxv_next;
	logic [10:0] rxid_reg, rxid_next;
	logic [3:0]  rxdlc_reg, rxdlc_next;
	logic [63:0] rxdat_reg, rxdat_next;
	logic        errp_reg, errp_next;
	logic [4:0]  errk_reg, errk_next;
	logic [7:0]  c0, dp, ap, c0n, dpn, apn;
	logic [4:0]  err;
	logic        ok, stf, b;

	// bit time reference shared over the link
	always_comb begin
		div_next  = (div_reg == 8'h00) ? 8'(BIT_CYC - 1) : div_reg - 8'h01;
		tick_next = (div_reg == 8'h00);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg  <= 8'h00;
			tick_reg <= 1'b0;
		end else begin
			div_reg  <= div_next;
			tick_reg <= tick_next;
		end
	end

	// field boundaries of the frame under way
	assign b   = link.bus;
	assign c0  = ced_c0(dlc_reg);
	assign dp  = c0 + `CED_CRC_LEN;
	assign ap  = dp + 8'h01;
	assign stf = (cnt_reg == `CED_STUFF_MAX) && (pos_reg <= dp);

	// frame engine, checks, counters and confinement
	always_comb begin
		st_next = st_reg;       pos_next = pos_reg;   cnt_next = cnt_reg;
		last_next = last_reg;   crc_next = crc_reg;   cbad_next = cbad_reg;
		txr_next = txr_reg;     drv_next = drv_reg;   pend_next = pend_reg;
		fr_next = fr_reg;       tsh_next = tsh_reg;   id_next = id_reg;
		dlc_next = dlc_reg;     dat_next = dat_reg;   tec_next = tec_reg;
		rec_next = rec_reg;     conf_next = conf_reg; errk_next = errk_reg;
		rxid_next = rxid_reg;   rxdlc_next = rxdlc_reg;
		rxdat_next = rxdat_reg;
		done_next = 1'b0;       rxv_next = 1'b0;      errp_next = 1'b0;
		err = 5'h00;
		ok = 1'b0;
		c0n = 8'h00;
		dpn = 8'h00;
		apn = 8'h00;
		if (tx_req && !pend_reg) begin
			pend_next = 1'b1;
			fr_next = {1'b0, tx_id, 3'h0, tx_dlc, ced_align(tx_data, tx_dlc)};
		end
		if (tick_reg) begin
			unique case (st_reg)
				CED_IDLE: begin
					if (!b) begin
						st_next = CED_FRAME;
						pos_next = 8'h01;
						cnt_next = 3'h1;
						last_next = 1'b0;
						crc_next = 15'h0000;
						cbad_next = 1'b0;
						dat_next = 64'h0;
						tsh_next = tsh_reg << 1;
					end else begin
						txr_next = pend_reg;
						tsh_next = fr_reg;
					end
				end
				CED_FRAME: begin
					if (stf) begin
						if (b == last_reg) begin
							if (txr_reg)
								err[`CED_E_BIT] = 1'b1;
							else
								err[`CED_E_STUFF] = 1'b1;
						end
						cnt_next = 3'h1; // dropped, not counted
						last_next = b;
					end else begin
						if (txr_reg && b != drv_reg && pos_reg != ap) begin
							if (pos_reg <= `CED_ARB_END && drv_reg)
								txr_next = 1'b0; // lost arbitration
							else
								err[`CED_E_BIT] = 1'b1;
						end
						if (pos_reg < c0)
							crc_next = ced_crc(crc_reg, b);
						else if (pos_reg < dp) begin
							if (b != crc_reg[14])
								cbad_next = 1'b1;
							crc_next = {crc_reg[13:0], 1'b0};
						end
						if (pos_reg < dp) begin
							cnt_next = (b == last_reg) ? cnt_reg + 3'h1 : 3'h1;
							last_next = b;
						end
						if (pos_reg < `CED_ARB_END)
							id_next = {id_reg[9:0], b};
						if (pos_reg >= `CED_P_DLC && pos_reg < `CED_P_DAT)
							dlc_next = {dlc_reg[2:0], b};
						if (pos_reg >= `CED_P_DAT && pos_reg < c0)
							dat_next = {dat_reg[62:0], b};
						if (pos_reg == dp && cbad_reg && !txr_reg)
							err[`CED_E_CRC] = 1'b1;
						if (pos_reg == ap && txr_reg && b)
							err[`CED_E_ACK] = 1'b1;
						if ((pos_reg == dp || pos_reg > ap) && !b)
							err[`CED_E_FORM] = 1'b1;
						if (pos_reg == ap + `CED_EOF_LEN + 8'h01)
							ok = 1'b1;
						pos_next = pos_reg + 8'h01;
						tsh_next = tsh_reg << 1;
					end
				end
				CED_FLAG: begin
					pos_next = pos_reg + 8'h01;
					if (pos_reg == `CED_FLAG_LEN - 8'h01) begin
						st_next = CED_DELIM;
						pos_next = 8'h00;
					end
				end
				CED_DELIM: begin
					pos_next = b ? pos_reg + 8'h01 : 8'h00;
					if (b && pos_reg == `CED_DELIM_LEN - 8'h01)
						st_next = CED_IDLE;
				end
				default: st_next = CED_IDLE;
			endcase
		end
		// error: flag, frame dropped, counter raised
		if (err != 5'h00) begin
			st_next = CED_FLAG;
			pos_next = 8'h00;
			errp_next = 1'b1;
			errk_next = err;
			txr_next = 1'b0;
			if (txr_reg)
				tec_next = (tec_reg > `CED_CNT_MAX - `CED_TEC_INC) ?
					`CED_CNT_MAX : tec_reg + `CED_TEC_INC;
			else
				rec_next = (rec_reg == `CED_CNT_MAX) ?
					`CED_CNT_MAX : rec_reg + `CED_REC_INC;
		end else if (ok) begin
			st_next = CED_IDLE;
			txr_next = 1'b0;
			if (txr_reg) begin
				done_next = 1'b1;
				pend_next = 1'b0;
				if (tec_reg != 9'h000)
					tec_next = tec_reg - 9'h001;
			end else begin
				rxv_next = 1'b1;
				rxid_next = id_reg;
				rxdlc_next = dlc_reg;
				rxdat_next = dat_reg;
				if (rec_reg != 9'h000)
					rec_next = rec_reg - 9'h001;
			end
		end
		// confinement state follows the counters
		if (conf_reg == CED_BUSOFF) begin
			if (recover) begin
				conf_next = CED_ACTIVE;
				tec_next = 9'h000;
				rec_next = 9'h000;
			end
		end else if (tec_next > `CED_BUSOFF_LIM)
			conf_next = CED_BUSOFF;
		else if (tec_next > `CED_PASSIVE_LIM || rec_next > `CED_PASSIVE_LIM)
			conf_next = CED_PASSIVE;
		else
			conf_next = CED_ACTIVE;
		if (conf_next == CED_BUSOFF) begin
			st_next = CED_IDLE;
			txr_next = 1'b0;
		end
		// level driven for the next bit
		if (tick_reg || conf_next == CED_BUSOFF) begin
			c0n = ced_c0(dlc_next);
			dpn = c0n + `CED_CRC_LEN;
			apn = dpn + 8'h01;
			drv_next = 1'b1;
			if (conf_next == CED_BUSOFF)
				drv_next = 1'b1;
			else if (st_next == CED_FLAG)
				drv_next = (conf_next != CED_ACTIVE);
			else if (st_next == CED_IDLE)
				drv_next = !txr_next;
			else if (st_next == CED_FRAME && txr_next) begin
				if (cnt_next == `CED_STUFF_MAX && pos_next <= dpn)
					drv_next = !last_next;
				else if (pos_next < c0n)
					drv_next = tsh_next[82];
				else if (pos_next < dpn)
					drv_next = crc_next[14];
			end else if (st_next == CED_FRAME && pos_next == apn && !cbad_next)
				drv_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= CED_IDLE;       conf_reg <= CED_ACTIVE;
			pos_reg <= 8'h00;         cnt_reg <= 3'h0;
			last_reg <= 1'b0;         crc_reg <= 15'h0000;
			cbad_reg <= 1'b0;         txr_reg <= 1'b0;
			drv_reg <= 1'b1;          pend_reg <= 1'b0;
			fr_reg <= 83'h0;          tsh_reg <= 83'h0;
			id_reg <= 11'h000;        dlc_reg <= 4'h0;
			dat_reg <= 64'h0;         tec_reg <= 9'h000;
			rec_reg <= 9'h000;        done_reg <= 1'b0;
			rxv_reg <= 1'b0;          rxid_reg <= 11'h000;
			rxdlc_reg <= 4'h0;        rxdat_reg <= 64'h0;
			errp_reg <= 1'b0;         errk_reg <= 5'h00;
		end else begin
			st_reg <= st_next;        conf_reg <= conf_next;
			pos_reg <= pos_next;      cnt_reg <= cnt_next;
			last_reg <= last_next;    crc_reg <= crc_next;
			cbad_reg <= cbad_next;    txr_reg <= txr_next;
			drv_reg <= drv_next;      pend_reg <= pend_next;
			fr_reg <= fr_next;        tsh_reg <= tsh_next;
			id_reg <= id_next;        dlc_reg <= dlc_next;
			dat_reg <= dat_next;      tec_reg <= tec_next;
			rec_reg <= rec_next;      done_reg <= done_next;
			rxv_reg <= rxv_next;      rxid_reg <= rxid_next;
			rxdlc_reg <= rxdlc_next;  rxdat_reg <= rxdat_next;
			errp_reg <= errp_next;    errk_reg <= errk_next;
		end
	end

	// outputs straight from flops
	assign link.dev_drv  = drv_reg;
	assign link.bit_tick = tick_reg;
	assign tx_busy       = pend_reg;
	assign tx_done       = done_reg;
	assign rx_valid      = rxv_reg;
	assign rx_id         = rxid_reg;
	assign rx_dlc        = rxdlc_reg;
	assign rx_data       = rxdat_reg;
	assign err_pulse     = errp_reg;
	assign err_kind      = errk_reg;
	assign tec           = tec_reg;
	assign rec           = rec_reg;
	assign conf          = conf_reg;
endmodule // ced_node_dev

/* hdl/ced_node_peer.sv */
`timescale 1ns/1ps
module ced_node_peer
	import ced_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	ced_bus_if.peer          link,
	input  wire logic        tx_req,
	input  wire logic [10:0] tx_id,
	input  wire logic [3:0]  tx_dlc,
	input  wire logic [63:0] tx_data,
	output logic             tx_busy,
	output logic             tx_done,
	output logic             rx_valid,
	output logic [10:0]      rx_id,
	output logic [3:0]       rx_dlc,
	output logic [63:0]      rx_data,
	output logic             err_pulse,
	output logic [4:0]       err_kind
);
	ced_st_t     st_reg, st_next;
	logic [7:0]  pos_reg, pos_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic        last_reg, last_next;
	logic [14:0] crc_reg, crc_next;
	logic        cbad_reg, cbad_next;
	logic        txr_reg, txr_next;
	logic        drv_reg, drv_next;
	logic        pend_reg, pend_next;
	logic [82:0] tsh_reg, tsh_next;
	logic [10:0] id_reg, id_next;
	logic [3:0]  dlc_reg, dlc_next;
	logic [63:0] dat_reg, dat_next;
	logic        done_reg, done_next;
	logic        rxv_reg, rxv_next;
	logic        errp_reg, errp_next;
	logic [4:0]  errk_reg, errk_next;
	logic [7:0]  c0, dp, ap, c0n, dpn;
	logic [4:0]  err;
	logic        ok, stf, b, tk;

	assign b   = link.bus;
	assign tk  = link.bit_tick;
	assign c0  = ced_c0(dlc_reg);
	assign dp  = c0 + `CED_CRC_LEN;
	assign ap  = dp + 8'h01;
	assign stf = (cnt_reg == `CED_STUFF_MAX) && (pos_reg <= dp);

	// frame engine of the far node, always error active
	always_comb begin
		st_next = st_reg;     pos_next = pos_reg;   cnt_next = cnt_reg;
		last_next = last_reg; crc_next = crc_reg;   cbad_next = cbad_reg;
		txr_next = txr_reg;   drv_next = drv_reg;   pend_next = pend_reg;
		tsh_next = tsh_reg;   id_next = id_reg;     dlc_next = dlc_reg;
		dat_next = dat_reg;   errk_next = errk_reg;
		done_next = 1'b0;     rxv_next = 1'b0;      errp_next = 1'b0;
		err = 5'h00;
		ok = 1'b0;
		c0n = 8'h00;
		dpn = 8'h00;
		if (tx_req && !pend_reg) begin
			pend_next = 1'b1;
			tsh_next = {1'b0, tx_id, 3'h0, tx_dlc, ced_align(tx_data, tx_dlc)};
		end
		if (tk) begin
			unique case (st_reg)
				CED_IDLE: begin
					if (!b) begin
						st_next = CED_FRAME;
						pos_next = 8'h01;
						cnt_next = 3'h1;
						last_next = 1'b0;
						crc_next = 15'h0000;
						cbad_next = 1'b0;
						dat_next = 64'h0;
						tsh_next = tsh_reg << 1;
					end else
						txr_next = pend_reg;
				end
				CED_FRAME: begin
					if (stf) begin
						if (b == last_reg)
							err[txr_reg ? `CED_E_BIT : `CED_E_STUFF] = 1'b1;
						cnt_next = 3'h1; // dropped, not counted
						last_next = b;
					end else begin
						if (txr_reg && b != drv_reg && pos_reg != ap) begin
							if (pos_reg <= `CED_ARB_END && drv_reg)
								txr_next = 1'b0;
							else
								err[`CED_E_BIT] = 1'b1;
						end
						if (pos_reg < c0)
							crc_next = ced_crc(crc_reg, b);
						else if (pos_reg < dp) begin
							if (b != crc_reg[14])
								cbad_next = 1'b1;
							crc_next = {crc_reg[13:0], 1'b0};
						end
						if (pos_reg < dp) begin
							cnt_next = (b == last_reg) ? cnt_reg + 3'h1 : 3'h1;
							last_next = b;
						end
						if (pos_reg < `CED_ARB_END)
							id_next = {id_reg[9:0], b};
						if (pos_reg >= `CED_P_DLC && pos_reg < `CED_P_DAT)
							dlc_next = {dlc_reg[2:0], b};
						if (pos_reg >= `CED_P_DAT && pos_reg < c0)
							dat_next = {dat_reg[62:0], b};
						if (pos_reg == dp && cbad_reg && !txr_reg)
							err[`CED_E_CRC] = 1'b1;
						if (pos_reg == ap && txr_reg && b)
							err[`CED_E_ACK] = 1'b1;
						if ((pos_reg == dp || pos_reg > ap) && !b)
							err[`CED_E_FORM] = 1'b1;
						if (pos_reg == ap + `CED_EOF_LEN + 8'h01)
							ok = 1'b1;
						pos_next = pos_reg + 8'h01;
						tsh_next = tsh_reg << 1;
					end
				end
				CED_FLAG: begin
					pos_next = pos_reg + 8'h01;
					if (pos_reg == `CED_FLAG_LEN - 8'h01) begin
						st_next = CED_DELIM;
						pos_next = 8'h00;
					end
				end
				CED_DELIM: begin
					pos_next = b ? pos_reg + 8'h01 : 8'h00;
					if (b && pos_reg == `CED_DELIM_LEN - 8'h01)
						st_next = CED_IDLE;
				end
				default: st_next = CED_IDLE;
			endcase
		end
		if (err != 5'h00) begin
			st_next = CED_FLAG; // flag and discard
			pos_next = 8'h00;
			errp_next = 1'b1;
			errk_next = err;
			txr_next = 1'b0;
		end else if (ok) begin
			st_next = CED_IDLE;
			txr_next = 1'b0;
			done_next = txr_reg;
			rxv_next = !txr_reg;
			if (txr_reg)
				pend_next = 1'b0;
		end
		// level driven for the next bit
		if (tk) begin
			c0n = ced_c0(dlc_next);
			dpn = c0n + `CED_CRC_LEN;
			drv_next = 1'b1;
			if (st_next == CED_FLAG)
				drv_next = 1'b0;
			else if (st_next == CED_IDLE)
				drv_next = !txr_next;
			else if (st_next == CED_FRAME && txr_next) begin
				if (cnt_next == `CED_STUFF_MAX && pos_next <= dpn)
					drv_next = !last_next;
				else if (pos_next < c0n)
					drv_next = tsh_next[82];
				else if (pos_next < dpn)
					drv_next = crc_next[14];
			end else if (st_next == CED_FRAME && pos_next == dpn + 8'h01
				&& !cbad_next)
				drv_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= CED_IDLE;   pos_reg <= 8'h00;    cnt_reg <= 3'h0;
			last_reg <= 1'b0;     crc_reg <= 15'h0000; cbad_reg <= 1'b0;
			txr_reg <= 1'b0;      drv_reg <= 1'b1;     pend_reg <= 1'b0;
			tsh_reg <= 83'h0;     id_reg <= 11'h000;   dlc_reg <= 4'h0;
			dat_reg <= 64'h0;     done_reg <= 1'b0;    rxv_reg <= 1'b0;
			errp_reg <= 1'b0;     errk_reg <= 5'h00;
		end else begin
			st_reg <= st_next;    pos_reg <= pos_next; cnt_reg <= cnt_next;
			last_reg <= last_next; crc_reg <= crc_next;
			cbad_reg <= cbad_next; txr_reg <= txr_next;
			drv_reg <= drv_next;  pend_reg <= pend_next;
			tsh_reg <= tsh_next;  id_reg <= id_next;   dlc_reg <= dlc_next;
			dat_reg <= dat_next;  done_reg <= done_next;
			rxv_reg <= rxv_next;  errp_reg <= errp_next;
			errk_reg <= errk_next;
		end
	end

	assign link.peer_drv = drv_reg;
	assign tx_busy       = pend_reg;
	assign tx_done       = done_reg;
	assign rx_valid      = rxv_reg;
	assign rx_id         = id_reg;
	assign rx_dlc        = dlc_reg;
	assign rx_data       = dat_reg;
	assign err_pulse     = errp_reg;
	assign err_kind      = errk_reg;
endmodule // ced_node_peer

/* hdl/ced_pkg.sv */
`include "ced_defines.svh"
package ced_pkg;
	typedef enum logic [3:0] {
		CED_IDLE  = 4'b0001,
		CED_FRAME = 4'b0010,
		CED_FLAG  = 4'b0100,
		CED_DELIM = 4'b1000
	} ced_st_t;

	typedef enum logic [2:0] {
		CED_ACTIVE  = 3'b001,
		CED_PASSIVE = 3'b010,
		CED_BUSOFF  = 3'b100
	} ced_conf_t;

	// one crc step over a destuffed bit
	function automatic logic [14:0] ced_crc(input logic [14:0] c,
		input logic b);
		ced_crc = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? `CED_CRC_POLY : 15'h0000);
	endfunction

	// data length clipped to eight bytes
	function automatic logic [3:0] ced_len(input logic [3:0] dlc);
		ced_len = (dlc > 4'h8) ? 4'h8 : dlc;
	endfunction

	// position of the first crc bit
	function automatic logic [7:0] ced_c0(input logic [3:0] dlc);
		ced_c0 = `CED_P_DAT + {1'b0, ced_len(dlc), 3'h0};
	endfunction

	// move the payload so its first bit sits at the top
	function automatic logic [63:0] ced_align(input logic [63:0] d,
		input logic [3:0] dlc);
		ced_align = d << (7'h40 - {ced_len(dlc), 3'h0});
	endfunction
endpackage

/* sim/ced_assertions.sv */
`timescale 1ns/1ps
// wire-level checks on the link between the two nodes
module ced_chk #(
	parameter int BIT_CYC = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic dev_drv,
	input wire logic peer_drv,
	input wire logic bit_tick,
	input wire logic bus
);
	logic [8:0] gap_reg, gap_next;
	logic [3:0] bus_reg, bus_next;
	logic [3:0] dev_reg, dev_next;
	logic [3:0] peer_reg, peer_next;
	logic       seen_reg, seen_next;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// cycles since the last tick and dominant run lengths at ticks
	always_comb begin
		gap_next  = bit_tick ? 9'h000 : gap_reg + 9'h001;
		seen_next = seen_reg | bit_tick;
		bus_next  = !bit_tick ? bus_reg : (bus ? 4'h0 : bus_reg + 4'h1);
		dev_next  = !bit_tick ? dev_reg : (dev_drv ? 4'h0 : dev_reg + 4'h1);
		peer_next = !bit_tick ? peer_reg : (peer_drv ? 4'h0 : peer_reg + 4'h1);
	end

	// register the helper counts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gap_reg  <= 9'h000;
			seen_reg <= 1'b0;
			bus_reg  <= 4'h0;
			dev_reg  <= 4'h0;
			peer_reg <= 4'h0;
		end else begin
			gap_reg  <= gap_next;
			seen_reg <= seen_next;
			bus_reg  <= bus_next;
			dev_reg  <= dev_next;
			peer_reg <= peer_next;
		end
	end

	property p_tick_pulse;
		bit_tick |=> !bit_tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse)
		else $error("bit tick longer than one cycle");

	property p_tick_gap;
		bit_tick && seen_reg |-> gap_reg == BIT_CYC - 1;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("bit tick spacing wrong");

	property p_dev_hold;
		$changed(dev_drv) |-> $past(bit_tick) || $past(bit_tick, 2);
	endproperty
	a_dev_hold: assert property (p_dev_hold)
		else $error("device drive changed inside a bit");

	property p_peer_hold;
		$changed(peer_drv) |-> $past(bit_tick) || $past(bit_tick, 2);
	endproperty
	a_peer_hold: assert property (p_peer_hold)
		else $error("far node drive changed inside a bit");

	property p_bus_run;
		bit_tick && !bus |-> bus_reg < 4'h5;
	endproperty
	a_bus_run: assert property (p_bus_run)
		else $error("six dominant bits on the bus");

	property p_dev_run;
		bit_tick && !dev_drv |-> dev_reg < 4'h5;
	endproperty
	a_dev_run: assert property (p_dev_run)
		else $error("device sent six dominant bits");

	property p_peer_run;
		bit_tick && !peer_drv |-> peer_reg < 4'h5;
	endproperty
	a_peer_run: assert property (p_peer_run)
		else $error("far node sent six dominant bits");

	property p_rst_idle;
		rst_n && !$past(rst_n) |-> dev_drv && peer_drv && !bit_tick;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("link not idle after reset");

	property p_first_tick;
		rst_n && !$past(rst_n) |-> ##[1:3] bit_tick;
	endproperty
	a_first_tick: assert property (p_first_tick)
		else $error("first bit tick late");
endmodule // ced_chk

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "ced_defines.svh"
module tb_top;
	import ced_pkg::*;
	localparam int BC = 4;
	logic        clk, rst_n, rc, d_req, p_req, e_req;
	logic        d_dn, d_rv, d_ep, p_dn, p_rv, p_ep, e_ep;
	logic [10:0] t_id, d_id, p_id;
	logic [3:0]  t_dlc, d_dl, p_dl;
	logic [63:0] t_dat, d_dt, p_dt;
	logic [4:0]  e_ek;
	logic [8:0]  d_tec, d_rec, e_tec, e_rec;
	ced_conf_t   d_cf, e_cf;
	int          error_cnt, checks, q_n, e_n, c_n;

	ced_bus_if lk ();
	ced_bus_if lk2 ();

	ced_node_dev #(.BIT_CYC(BC)) ced_node_dev_i (.clk, .rst_n, .link(lk.dev),
		.tx_req(d_req), .tx_id(t_id), .tx_dlc(t_dlc), .tx_data(t_dat),
		.recover(rc), .tx_busy(), .tx_done(d_dn), .rx_valid(d_rv),
		.rx_id(d_id), .rx_dlc(d_dl), .rx_data(d_dt), .err_pulse(d_ep),
		.err_kind(), .tec(d_tec), .rec(d_rec), .conf(d_cf));
	ced_node_peer ced_node_peer_i (.clk, .rst_n, .link(lk.peer),
		.tx_req(p_req), .tx_id(t_id), .tx_dlc(t_dlc), .tx_data(t_dat),
		.tx_busy(), .tx_done(p_dn), .rx_valid(p_rv), .rx_id(p_id),
		.rx_dlc(p_dl), .rx_data(p_dt), .err_pulse(p_ep), .err_kind());
	// second device faces a bench driver that breaks the rules
	ced_node_dev #(.BIT_CYC(BC)) ced_node_dev_i2 (.clk, .rst_n,
		.link(lk2.dev), .tx_req(e_req), .tx_id(t_id), .tx_dlc(t_dlc),
		.tx_data(t_dat), .recover(rc), .tx_busy(), .tx_done(),
		.rx_valid(), .rx_id(), .rx_dlc(), .rx_data(), .err_pulse(e_ep),
		.err_kind(e_ek), .tec(e_tec), .rec(e_rec), .conf(e_cf));
	ced_chk #(.BIT_CYC(BC)) ced_chk_i (.clk, .rst_n, .dev_drv(lk.dev_drv),
		.peer_drv(lk.peer_drv), .bit_tick(lk.bit_tick), .bus(lk.bus));

	// clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// error pulses on the clean and the faulty link
	always @(posedge clk) begin
		if (d_ep === 1'b1 || p_ep === 1'b1)
			q_n++;
		if (e_ep === 1'b1)
			e_n++;
	end

	task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task results;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// falling edge just before a tick edge on the faulty link
	task tick;
		@(negedge clk);
		while (lk2.bit_tick !== 1'b1)
			@(negedge clk);
	endtask

	// one frame on the clean link; dir high means the far node sends
	task send(input bit dir, input logic [10:0] id, input logic [3:0] dl,
		input logic [63:0] dt);
		logic [63:0] m;
		int n;
		m = dl > 4'h7 ? '1 : (64'h1 << (8 * dl)) - 64'h1;
		t_id = id;
		t_dlc = dl;
		t_dat = dt;
		d_req = !dir;
		p_req = dir;
		@(negedge clk);
		d_req = 1'b0;
		p_req = 1'b0;
		n = 0;
		while ((dir ? d_rv : p_rv) !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		chk("rx_id", dir ? d_id : p_id, id);
		chk("rx_dlc", dir ? d_dl : p_dl, dl);
		chk("rx_data", dir ? d_dt : p_dt, dt & m);
		chk("tx_done", dir ? p_dn : d_dn, 1'b1);
	endtask

	// watchdog, well past the expected run time
	initial begin
		#5_000_000;
		error_cnt++;
		results;
	end

	initial begin
		rst_n = 1'b0;
		{rc, d_req, p_req, e_req} = 4'h0;
		{t_id, t_dlc, t_dat} = '0;
		lk2.peer_drv = 1'b1;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		send(1'b0, 11'h000, 4'h0, 64'h0);
		send(1'b0, 11'h7ff, 4'h8, 64'hffff_0000_ffff_0000);
		send(1'b1, 11'h123, 4'hc, 64'h0123_4567_89ab_cdef);
		send(1'b1, 11'h555, 4'h3, 64'hdead_beef);
		send(1'b0, 11'h0f0, 4'h1, 64'h0000_0000_0000_00ff);
		chk("clean_errs", q_n, 0);
		chk("tec", d_tec, 0);
		chk("rec", d_rec, 0);
		chk("conf", d_cf, CED_ACTIVE);
		// eight dominant bits from idle on the faulty link
		tick;
		@(negedge clk);
		lk2.peer_drv = 1'b0;
		repeat (8) tick;
		@(negedge clk);
		lk2.peer_drv = 1'b1;
		chk("flag", lk2.dev_drv, 1'b0);
		repeat (20) tick;
		chk("stuff_errs", e_n, 1);
		chk("stuff_kind", e_ek[`CED_E_STUFF], 1'b1);
		chk("rec", e_rec, 1);
		// send, then force dominant from the bit before the first length bit on
		t_id = 11'h555;
		t_dlc = 4'h8;
		e_req = 1'b1;
		@(negedge clk);
		e_req = 1'b0;
		do
			tick;
		while (lk2.bus !== 1'b0);
		repeat (13) tick;
		@(negedge clk);
		lk2.peer_drv = 1'b0;
		repeat (8) tick;
		@(negedge clk);
		lk2.peer_drv = 1'b1;
		// retries stay unacknowledged until the node drops off
		for (int k = 1; k <= 32; k++) begin
			while (e_n < k + 1)
				@(negedge clk);
			repeat (2) @(negedge clk);
			chk("tec", e_tec, 8 * k);
			chk("conf", e_cf, k > 31 ? CED_BUSOFF : k > 15 ? CED_PASSIVE
				: CED_ACTIVE);
			if (k < 3)
				chk("kind", e_ek, k == 1 ? 5'h01 : 5'h08);
		end
		repeat (100) begin
			@(negedge clk);
			chk("off_drv", lk2.dev_drv, 1'b1);
		end
		chk("off_errs", e_n, 33);
		rc = 1'b1;
		@(negedge clk);
		rc = 1'b0;
		@(negedge clk);
		chk("tec", e_tec, 0);
		chk("conf", e_cf, CED_ACTIVE);
		// learn where the ack slot falls from one unacked attempt
		do
			tick;
		while (lk2.bus !== 1'b0);
		c_n = 0;
		while (e_ep !== 1'b1) begin
			@(negedge clk);
			c_n++;
		end
		chk("kind", e_ek, 5'h08);
		repeat (10) tick;
		// dominant over ack and its delimiter, then over the ack only
		for (int j = 2; j > 0; j--) begin
			do
				tick;
			while (lk2.bus !== 1'b0);
			repeat (c_n - 4) @(negedge clk);
			lk2.peer_drv = 1'b0;
			repeat (4 * j) @(negedge clk);
			lk2.peer_drv = 1'b1;
			repeat (12) tick;
			chk("errs", e_n, 35);
			chk("kind", e_ek, 5'h05);
			chk("tec", e_tec, j > 1 ? 16 : 15);
		end
		results;
	end
endmodule // tb_top
